// *** logic/pfc_pkg.sv ***
package pfc_pkg;
	localparam int SAMPLE_W  = 20;
	localparam int ACC_W     = 40;
	localparam int GAIN_FRAC = 15;
	localparam int TONE_FRAC = 8;
	localparam int CODE_W    = 6;
	localparam int TONE_W    = 5;

	////////////////////////////////////////////////////////////////
	// control bus framing
	localparam logic [5:0] DEVICE_ADDR  = 6'h05;
	localparam int         ADDR_LO      = 2;
	localparam int         XFER_LO      = 0;
	localparam logic [1:0] XFER_FEATURE = 2'h0;
	localparam logic [1:0] XFER_CONTROL = 2'h2;
	localparam int         SELECT_BIT   = 7;
	localparam int         FEAT_SEL_LO  = 6;
	localparam logic [1:0] FEAT_RIGHT   = 2'h0;
	localparam logic [1:0] FEAT_LEFT    = 2'h1;
	localparam logic [1:0] FEAT_BASS    = 2'h2;
	localparam logic [1:0] FEAT_TREBLE  = 2'h3;
	localparam logic [2:0] LAST_BIT     = 3'h7;

	////////////////////////////////////////////////////////////////
	// general control fields
	localparam int C0_RESET   = 0;
	localparam int C0_MUTE    = 1;
	localparam int C0_SYNC    = 2;
	localparam int C0_SWAP    = 3;
	localparam int C0_DEEMPH  = 4;
	localparam int C0_TONE_LO = 5;
	localparam int C1_FMT_LO  = 0;
	localparam int C1_PLLM_LO = 2;
	localparam int C1_LOCKM   = 4;
	localparam int C1_SPD_LO  = 5;
	localparam logic [7:0] CTRL0_RESET_VAL = 8'h00;
	localparam logic [7:0] CTRL1_RESET_VAL = 8'h00;
	localparam logic [5:0] VOL_RESET_VAL   = 6'h00;
	localparam logic [4:0] TONE_RESET_VAL  = 5'h00;
	localparam logic [1:0] TONE_FLAT       = 2'h0;
	localparam logic [1:0] TONE_MAX        = 2'h3;

	////////////////////////////////////////////////////////////////
	// lock counts in samples, ramp steps and volume codes
	localparam logic [13:0] LOCK_SAMPLES_0 = 14'h0200;
	localparam logic [13:0] LOCK_SAMPLES_1 = 14'h0800;
	localparam logic [13:0] LOCK_SAMPLES_2 = 14'h1000;
	localparam logic [13:0] LOCK_SAMPLES_3 = 14'h3FDC;
	localparam logic [5:0]  RAMP_STEPS     = 6'h20;
	localparam logic [4:0]  RAMP_LAST_REP  = 5'h1F;
	localparam logic [5:0]  VOL_UNITY_MAX  = 6'h01;
	localparam logic [5:0]  VOL_SILENT     = 6'h3E;
	localparam logic [5:0]  DB_PER_HALF    = 6'h06;

	// one-pole shifts, sized for a 44.1 kHz sample rate
	localparam int DEEMPH_SH     = 1;
	localparam int TREBLE_SH_MIN = 1;
	localparam int TREBLE_SH_MAX = 2;
	localparam int BASS_SH_MIN   = 6;
	localparam int BASS_SH_MAX   = 7;

	typedef enum logic [1:0] {SEL_NONE, SEL_FEATURE, SEL_CONTROL} pfc_sel_t;
endpackage

// *** logic/pfc_mute_ramp.sv ***
`timescale 1ns/100ps
module pfc_mute_ramp (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        step,
	input  wire logic        clear,
	input  wire logic        mute,
	output logic      [15:0] gain,
	output logic             silent
);
	logic [5:0] idx_ff;
	logic [4:0] rep_ff;
	logic       moving;

	localparam logic [15:0] COEF [32] = '{
		16'h7FFF, 16'h7FB0, 16'h7EC5, 16'h7D3E, 16'h7B20, 16'h7871, 16'h7537, 16'h7179,
		16'h6D41, 16'h6897, 16'h638C, 16'h5E2B, 16'h587E, 16'h5293, 16'h4C7C, 16'h4645,
		16'h4000, 16'h39BA, 16'h3383, 16'h2D6C, 16'h2781, 16'h21D4, 16'h1C73, 16'h1768,
		16'h12BE, 16'h0E86, 16'h0AC8, 16'h078E, 16'h04DF, 16'h02C1, 16'h013A, 16'h004F};

	// index 0 is full level, RAMP_STEPS is silence
	assign moving = mute ? (idx_ff != pfc_pkg::RAMP_STEPS) : (idx_ff != 6'h00);
	assign silent = (idx_ff == pfc_pkg::RAMP_STEPS);
	assign gain   = silent ? 16'h0000 : COEF[idx_ff[4:0]];

	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			idx_ff <= pfc_pkg::RAMP_STEPS;
			rep_ff <= 5'h00;
		end else if (step) begin
			if (moving) begin
				rep_ff <= rep_ff + 5'h01;
				if (rep_ff == pfc_pkg::RAMP_LAST_REP) begin
					idx_ff <= mute ? idx_ff + 6'h01 : idx_ff - 6'h01;
				end
			end else begin
				rep_ff <= 5'h00;
			end
		end
	end
endmodule

// *** logic/pfc_channel.sv ***
`timescale 1ns/100ps
module pfc_channel (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        step,
	input  wire logic        clear,
	input  wire logic [19:0] din,
	input  wire logic        deemph_en,
	input  wire logic        max_mode,
	input  wire logic [11:0] treble_gain,
	input  wire logic [11:0] bass_gain,
	input  wire logic [15:0] vol_gain,
	input  wire logic [3:0]  vol_shift,
	input  wire logic [15:0] ramp_gain,
	output logic      [19:0] dout
);
	localparam int AW = pfc_pkg::ACC_W;
	localparam logic signed [AW-1:0] SMAX = AW'(2 ** (pfc_pkg::SAMPLE_W - 1) - 1);
	localparam logic signed [AW-1:0] SMIN = -SMAX - AW'(1);

	logic signed [AW-1:0] dem_ff, tlp_ff, blp_ff;
	logic signed [AW-1:0] x, d, tl, bl, t, v, r;
	logic        [19:0]   dout_ff;

	always_comb begin
		x  = AW'($signed(din));
		d  = deemph_en ? dem_ff + ((x - dem_ff) >>> pfc_pkg::DEEMPH_SH) : x;
		tl = tlp_ff + ((d - tlp_ff) >>> (max_mode ? pfc_pkg::TREBLE_SH_MAX : pfc_pkg::TREBLE_SH_MIN));
		bl = blp_ff + ((d - blp_ff) >>> (max_mode ? pfc_pkg::BASS_SH_MAX : pfc_pkg::BASS_SH_MIN));
		t  = d + ((((d - tl) * $signed({1'b0, treble_gain})) >>> pfc_pkg::TONE_FRAC)
			+ ((bl * $signed({1'b0, bass_gain})) >>> pfc_pkg::TONE_FRAC));
		v  = ((t * $signed({1'b0, vol_gain})) >>> pfc_pkg::GAIN_FRAC) >>> vol_shift;
		r  = (v * $signed({1'b0, ramp_gain})) >>> pfc_pkg::GAIN_FRAC;
	end

	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			dem_ff  <= '0;
			tlp_ff  <= '0;
			blp_ff  <= '0;
			dout_ff <= 20'h00000;
		end else if (step) begin
			dem_ff <= d;
			tlp_ff <= tl;
			blp_ff <= bl;
			if (r > SMAX) begin
				dout_ff <= SMAX[19:0];
			end else if (r < SMIN) begin
				dout_ff <= SMIN[19:0];
			end else begin
				dout_ff <= r[19:0];
			end
		end
	end

	assign dout = dout_ff;
endmodule

// *** logic/pfc_playback_ctrl.sv ***
`timescale 1ns/100ps
module pfc_playback_ctrl (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        TWB_MODE,
	input  wire logic        TWB_CLK,
	input  wire logic        TWB_DATA,
	input  wire logic        SAMPLE_STROBE,
	input  wire logic [19:0] IN_LEFT,
	input  wire logic [19:0] IN_RIGHT,
	output logic      [19:0] OUT_LEFT,
	output logic      [19:0] OUT_RIGHT,
	output logic             OUT_VALID,
	output logic             CONVERTER_RESET,
	output logic             MUTE_SILENT,
	output logic             PLL_LOCKED,
	output logic             SYNC_SELECT,
	output logic      [1:0]  INPUT_FORMAT,
	output logic      [1:0]  PLL_MODE,
	output logic             LOCK_MODE
);
	////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic mode_s1_ff, mode_s2_ff, mode_d_ff;
	logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
	logic data_s1_ff, data_s2_ff;
	logic bit_rise;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mode_s1_ff <= 1'b0;
			mode_s2_ff <= 1'b0;
			mode_d_ff  <= 1'b0;
			clk_s1_ff  <= 1'b1;
			clk_s2_ff  <= 1'b1;
			clk_s3_ff  <= 1'b1;
			data_s1_ff <= 1'b0;
			data_s2_ff <= 1'b0;
		end else begin
			mode_s1_ff <= TWB_MODE;
			mode_s2_ff <= mode_s1_ff;
			mode_d_ff  <= mode_s2_ff;
			clk_s1_ff  <= TWB_CLK;
			clk_s2_ff  <= clk_s1_ff;
			clk_s3_ff  <= clk_s2_ff;
			data_s1_ff <= TWB_DATA;
			data_s2_ff <= data_s1_ff;
		end
	end

	assign bit_rise = clk_s2_ff & ~clk_s3_ff;

	////////////////////////////////////////////////////////////////
	// byte assembly, least significant bit first
	logic [7:0] shift_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] byte_ff;
	logic       byte_mode_ff;
	logic       byte_vld_ff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			shift_ff     <= 8'h00;
			bit_cnt_ff   <= 3'h0;
			byte_ff      <= 8'h00;
			byte_mode_ff <= 1'b0;
			byte_vld_ff  <= 1'b0;
		end else begin
			byte_vld_ff <= 1'b0;
			if (mode_s2_ff != mode_d_ff) begin
				bit_cnt_ff <= 3'h0;
			end else if (bit_rise) begin
				shift_ff   <= {data_s2_ff, shift_ff[7:1]};
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				if (bit_cnt_ff == pfc_pkg::LAST_BIT) begin
					byte_ff      <= {data_s2_ff, shift_ff[7:1]};
					byte_mode_ff <= mode_s2_ff;
					byte_vld_ff  <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// address phase selects the register group
	pfc_pkg::pfc_sel_t sel_ff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sel_ff <= pfc_pkg::SEL_NONE;
		end else if (byte_vld_ff && !byte_mode_ff) begin
			if (byte_ff[7:pfc_pkg::ADDR_LO] != pfc_pkg::DEVICE_ADDR) begin
				sel_ff <= pfc_pkg::SEL_NONE;
			end else if (byte_ff[pfc_pkg::XFER_LO +: 2] == pfc_pkg::XFER_CONTROL) begin
				sel_ff <= pfc_pkg::SEL_CONTROL;
			end else if (byte_ff[pfc_pkg::XFER_LO +: 2] == pfc_pkg::XFER_FEATURE) begin
				sel_ff <= pfc_pkg::SEL_FEATURE;
			end else begin
				sel_ff <= pfc_pkg::SEL_NONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// written registers
	logic [7:0] ctrl0_ff, ctrl1_ff;
	logic [5:0] vol_r_ff, vol_l_ff;
	logic [4:0] bass_ff, treble_ff;
	logic       data_wr;

	assign data_wr = byte_vld_ff && byte_mode_ff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl0_ff  <= pfc_pkg::CTRL0_RESET_VAL;
			ctrl1_ff  <= pfc_pkg::CTRL1_RESET_VAL;
			vol_r_ff  <= pfc_pkg::VOL_RESET_VAL;
			vol_l_ff  <= pfc_pkg::VOL_RESET_VAL;
			bass_ff   <= pfc_pkg::TONE_RESET_VAL;
			treble_ff <= pfc_pkg::TONE_RESET_VAL;
		end else if (data_wr) begin
			unique case (sel_ff)
				pfc_pkg::SEL_CONTROL: begin
					if (byte_ff[pfc_pkg::SELECT_BIT]) begin
						ctrl1_ff <= byte_ff;
					end else begin
						ctrl0_ff <= byte_ff;
					end
				end
				pfc_pkg::SEL_FEATURE: begin
					unique case (byte_ff[pfc_pkg::FEAT_SEL_LO +: 2])
						pfc_pkg::FEAT_RIGHT:  vol_r_ff  <= byte_ff[5:0];
						pfc_pkg::FEAT_LEFT:   vol_l_ff  <= byte_ff[5:0];
						pfc_pkg::FEAT_BASS:   bass_ff   <= byte_ff[4:0];
						pfc_pkg::FEAT_TREBLE: treble_ff <= byte_ff[4:0];
					endcase
				end
				pfc_pkg::SEL_NONE: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// working copies, taken only at sample boundaries
	logic [7:0] act_c0_ff, act_c1_ff;
	logic [5:0] act_vol_ff [2];
	logic [4:0] act_bass_ff, act_treble_ff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			act_c0_ff     <= pfc_pkg::CTRL0_RESET_VAL;
			act_c1_ff     <= pfc_pkg::CTRL1_RESET_VAL;
			act_vol_ff[0] <= pfc_pkg::VOL_RESET_VAL;
			act_vol_ff[1] <= pfc_pkg::VOL_RESET_VAL;
			act_bass_ff   <= pfc_pkg::TONE_RESET_VAL;
			act_treble_ff <= pfc_pkg::TONE_RESET_VAL;
		end else if (SAMPLE_STROBE) begin
			act_c0_ff     <= ctrl0_ff;
			act_c1_ff     <= ctrl1_ff;
			act_vol_ff[0] <= vol_l_ff;
			act_vol_ff[1] <= vol_r_ff;
			act_bass_ff   <= bass_ff;
			act_treble_ff <= treble_ff;
		end
	end

	logic       conv_reset;
	logic       conv_clear;
	logic [1:0] tone_mode;
	logic       tone_on;
	logic       max_mode;

	assign conv_reset = act_c0_ff[pfc_pkg::C0_RESET];
	// zeroing lands on the strobe that raises the reset, never between samples
	assign conv_clear = SAMPLE_STROBE && ctrl0_ff[pfc_pkg::C0_RESET];
	assign tone_mode  = act_c0_ff[pfc_pkg::C0_TONE_LO +: 2];
	assign tone_on    = (tone_mode != pfc_pkg::TONE_FLAT);
	assign max_mode   = (tone_mode == pfc_pkg::TONE_MAX);

	////////////////////////////////////////////////////////////////
	// digital PLL lock counting
	logic [13:0] lock_cnt_ff;
	logic        locked_ff;
	logic [13:0] lock_target;

	always_comb begin
		unique case (act_c1_ff[pfc_pkg::C1_SPD_LO +: 2])
			2'h0: lock_target = pfc_pkg::LOCK_SAMPLES_0;
			2'h1: lock_target = pfc_pkg::LOCK_SAMPLES_1;
			2'h2: lock_target = pfc_pkg::LOCK_SAMPLES_2;
			2'h3: lock_target = pfc_pkg::LOCK_SAMPLES_3;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N || conv_reset) begin
			lock_cnt_ff <= 14'h0000;
			locked_ff   <= 1'b0;
		end else if (SAMPLE_STROBE && !locked_ff) begin
			lock_cnt_ff <= lock_cnt_ff + 14'h0001;
			if (lock_cnt_ff + 14'h0001 >= lock_target) begin
				locked_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// soft mute ramp, also held down while out of lock
	logic [15:0] ramp_gain;
	logic        ramp_silent;

	pfc_mute_ramp u_ramp (
		.clk    (CLK),
		.rst_n  (RST_N),
		.step   (SAMPLE_STROBE),
		.clear  (conv_clear),
		.mute   (act_c0_ff[pfc_pkg::C0_MUTE] || !locked_ff),
		.gain   (ramp_gain),
		.silent (ramp_silent)
	);

	////////////////////////////////////////////////////////////////
	// gain tables
	function automatic logic [15:0] vol_mantissa(input logic [2:0] idx);
		unique case (idx)
			3'h0:    vol_mantissa = 16'h7FFF;
			3'h1:    vol_mantissa = 16'h7215;
			3'h2:    vol_mantissa = 16'h65AD;
			3'h3:    vol_mantissa = 16'h5A9E;
			3'h4:    vol_mantissa = 16'h50C3;
			3'h5:    vol_mantissa = 16'h47FB;
			default: vol_mantissa = 16'h0000;
		endcase
	endfunction

	// extra gain above unity, eight fraction bits
	function automatic logic [11:0] treble_extra(input logic [4:0] code);
		if (code[4]) begin
			treble_extra = 12'h0FF;
		end else begin
			unique case (code[3:2])
				2'h0: treble_extra = 12'h000;
				2'h1: treble_extra = 12'h042;
				2'h2: treble_extra = 12'h096;
				2'h3: treble_extra = 12'h0FF;
			endcase
		end
	endfunction

	function automatic logic [11:0] bass_extra(input logic [4:0] code, input logic maxm);
		logic [11:0] lo, hi;
		lo = 12'h000;
		hi = 12'h000;
		unique case (code[4:1])
			4'h0, 4'h1: begin lo = 12'h000; hi = 12'h000; end
			4'h2:       begin lo = 12'h023; hi = 12'h037; end
			4'h3:       begin lo = 12'h051; hi = 12'h084; end
			4'h4:       begin lo = 12'h088; hi = 12'h0DD; end
			4'h5:       begin lo = 12'h0D2; hi = 12'h158; end
			4'h6:       begin lo = 12'h130; hi = 12'h1F4; end
			4'h7:       begin lo = 12'h1A1; hi = 12'h2AC; end
			4'h8:       begin lo = 12'h23C; hi = 12'h3A0; end
			4'h9:       begin lo = 12'h2F0; hi = 12'h4C1; end
			4'hA:       begin lo = 12'h3D8; hi = 12'h654; end
			4'hB:       begin lo = 12'h3D8; hi = 12'h81F; end
			4'hC:       begin lo = 12'h3D8; hi = 12'hA7B; end
			default:    begin lo = 12'h3D8; hi = 12'hD73; end
		endcase
		bass_extra = maxm ? hi : lo;
	endfunction

	logic [11:0] treble_gain, bass_gain;

	assign treble_gain = tone_on ? treble_extra(act_treble_ff) : 12'h000;
	assign bass_gain   = tone_on ? bass_extra(act_bass_ff, max_mode) : 12'h000;

	////////////////////////////////////////////////////////////////
	// channels: index 0 left, 1 right
	logic [19:0] ch_in  [2];
	logic [19:0] ch_out [2];

	assign ch_in[0] = act_c0_ff[pfc_pkg::C0_SWAP] ? IN_RIGHT : IN_LEFT;
	assign ch_in[1] = act_c0_ff[pfc_pkg::C0_SWAP] ? IN_LEFT : IN_RIGHT;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic [5:0]  att;
			logic [3:0]  vshift;
			logic [15:0] vgain;

			// 6 dB is close enough to one halving for the exponent part
			assign att    = (act_vol_ff[g] <= pfc_pkg::VOL_UNITY_MAX) ? 6'h00 : act_vol_ff[g] - 6'h01;
			assign vshift = 4'(att / pfc_pkg::DB_PER_HALF);
			assign vgain  = (act_vol_ff[g] >= pfc_pkg::VOL_SILENT) ? 16'h0000
				: vol_mantissa(3'(att % pfc_pkg::DB_PER_HALF));

			pfc_channel u_chan (
				.clk         (CLK),
				.rst_n       (RST_N),
				.step        (SAMPLE_STROBE),
				.clear       (conv_clear),
				.din         (ch_in[g]),
				.deemph_en   (act_c0_ff[pfc_pkg::C0_DEEMPH]),
				.max_mode    (max_mode),
				.treble_gain (treble_gain),
				.bass_gain   (bass_gain),
				.vol_gain    (vgain),
				.vol_shift   (vshift),
				.ramp_gain   (ramp_gain),
				.dout        (ch_out[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// outputs
	logic valid_ff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= SAMPLE_STROBE && !conv_reset;
		end
	end

	assign OUT_LEFT        = ch_out[0];
	assign OUT_RIGHT       = ch_out[1];
	assign OUT_VALID       = valid_ff;
	assign CONVERTER_RESET = conv_reset;
	assign MUTE_SILENT     = ramp_silent;
	assign PLL_LOCKED      = locked_ff;
	assign SYNC_SELECT     = act_c0_ff[pfc_pkg::C0_SYNC];
	assign INPUT_FORMAT    = act_c1_ff[pfc_pkg::C1_FMT_LO +: 2];
	assign PLL_MODE        = act_c1_ff[pfc_pkg::C1_PLLM_LO +: 2];
	assign LOCK_MODE       = act_c1_ff[pfc_pkg::C1_LOCKM];
endmodule

// *** verif/pfc_playback_ctrl_sva.sv ***
`timescale 1ns/100ps
module pfc_playback_ctrl_sva (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        SAMPLE_STROBE,
	input wire logic [19:0] OUT_LEFT,
	input wire logic [19:0] OUT_RIGHT,
	input wire logic        OUT_VALID,
	input wire logic        CONVERTER_RESET,
	input wire logic        MUTE_SILENT,
	input wire logic        PLL_LOCKED,
	input wire logic        SYNC_SELECT,
	input wire logic [1:0]  INPUT_FORMAT,
	input wire logic [1:0]  PLL_MODE,
	input wire logic        LOCK_MODE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_valid_cause;
		OUT_VALID |-> $past(SAMPLE_STROBE);
	endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("valid without strobe");
	property p_valid_pulse;
		OUT_VALID |=> !OUT_VALID;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");
	property p_out_hold;
		!SAMPLE_STROBE |=> $stable(OUT_LEFT) && $stable(OUT_RIGHT);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output moved between samples");
	property p_cfg_hold;
		!SAMPLE_STROBE |=> $stable({SYNC_SELECT, INPUT_FORMAT, PLL_MODE, LOCK_MODE, CONVERTER_RESET});
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("setting changed off sample boundary");
	property p_mute_step;
		!SAMPLE_STROBE |=> $stable(MUTE_SILENT);
	endproperty
	a_mute_step: assert property (p_mute_step) else $error("ramp moved off sample boundary");
	property p_conv_quiet;
		CONVERTER_RESET && $past(CONVERTER_RESET) |-> !OUT_VALID && OUT_LEFT == 20'h00000 && OUT_RIGHT == 20'h00000;
	endproperty
	a_conv_quiet: assert property (p_conv_quiet) else $error("audio during converter reset");
	property p_conv_unlock;
		CONVERTER_RESET && $past(CONVERTER_RESET) |-> !PLL_LOCKED;
	endproperty
	a_conv_unlock: assert property (p_conv_unlock) else $error("lock held in converter reset");
	property p_lock_edge;
		$rose(PLL_LOCKED) |-> $past(SAMPLE_STROBE);
	endproperty
	a_lock_edge: assert property (p_lock_edge) else $error("lock off sample boundary");
	property p_silent_zero;
		MUTE_SILENT && $past(MUTE_SILENT) && OUT_VALID |-> OUT_LEFT == 20'h00000 && OUT_RIGHT == 20'h00000;
	endproperty
	a_silent_zero: assert property (p_silent_zero) else $error("audio while ramp silent");
endmodule

// *** verif/pfc_host_model.sv ***
`timescale 1ns/100ps
module pfc_host_model (
	input  wire logic CLK,
	output logic      TWB_MODE,
	output logic      TWB_CLK,
	output logic      TWB_DATA
);
	initial begin
		TWB_MODE = 1'b0;
		TWB_CLK  = 1'b1;
		TWB_DATA = 1'b0;
	end
	// n bits lsb first, five cycles per phase
	task automatic bits(input logic m, input logic [7:0] d, input int n);
		@(negedge CLK) TWB_MODE = m;
		repeat (5) @(negedge CLK);
		for (int i = 0; i < n; i++) begin
			TWB_CLK  = 1'b0;
			TWB_DATA = d[i];
			repeat (5) @(negedge CLK);
			TWB_CLK = 1'b1;
			repeat (5) @(negedge CLK);
		end
		// hold time over: line no longer shows last bit
		TWB_DATA = ~TWB_DATA;
		repeat (5) @(negedge CLK);
	endtask
	task automatic write(input logic [1:0] kind, input logic [7:0] d, input logic [5:0] dev = 6'h05);
		bits(1'b0, {dev, kind}, 8);
		bits(1'b1, d, 8);
	endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/100ps
`define CHK(n, e, s) samples_checked++; if ((s) !== (e)) begin $display("mismatch %s exp %0h got %0h", n, e, s); bad_count++; end
module testbench;
	logic        CLK;
	logic        RST_N;
	logic        SAMPLE_STROBE;
	logic [19:0] IN_LEFT;
	logic [19:0] IN_RIGHT;
	logic [19:0] OUT_LEFT;
	logic [19:0] OUT_RIGHT;
	logic [19:0] v0;
	logic [19:0] vf;
	logic [1:0]  PLL_MODE;
	logic [1:0]  INPUT_FORMAT;
	logic        OUT_VALID, CONVERTER_RESET, MUTE_SILENT, PLL_LOCKED, SYNC_SELECT, LOCK_MODE;
	logic        TWB_MODE, TWB_CLK, TWB_DATA, valid_seen;
	int          bad_count, samples_checked, n;
	pfc_host_model pfc_host_model_i (.CLK(CLK), .TWB_MODE(TWB_MODE), .TWB_CLK(TWB_CLK), .TWB_DATA(TWB_DATA));
	pfc_playback_ctrl pfc_playback_ctrl_i (.CLK(CLK), .RST_N(RST_N), .TWB_MODE(TWB_MODE), .TWB_CLK(TWB_CLK),
		.TWB_DATA(TWB_DATA), .SAMPLE_STROBE(SAMPLE_STROBE), .IN_LEFT(IN_LEFT), .IN_RIGHT(IN_RIGHT),
		.OUT_LEFT(OUT_LEFT), .OUT_RIGHT(OUT_RIGHT), .OUT_VALID(OUT_VALID), .CONVERTER_RESET(CONVERTER_RESET),
		.MUTE_SILENT(MUTE_SILENT), .PLL_LOCKED(PLL_LOCKED), .SYNC_SELECT(SYNC_SELECT),
		.INPUT_FORMAT(INPUT_FORMAT), .PLL_MODE(PLL_MODE), .LOCK_MODE(LOCK_MODE));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	task automatic stop_test();
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic strobe(input int k);
		repeat (k) begin
			@(negedge CLK) SAMPLE_STROBE = 1'b1;
			@(negedge CLK) SAMPLE_STROBE = 1'b0;
			valid_seen = OUT_VALID;
			@(negedge CLK);
		end
	endtask
	task automatic wr(input logic [1:0] kind, input logic [7:0] d);
		pfc_host_model_i.write(kind, d);
		strobe(3);
	endtask
	task automatic t_lock_and_format();
		strobe(511);
		`CHK("lock_early", 1'b0, PLL_LOCKED)
		strobe(1);
		`CHK("lock_512", 1'b1, PLL_LOCKED)
		for (int k = 0; k < 4; k++) begin
			wr(2'h2, 8'h90 | 8'(k) | 8'(k << 2));
			`CHK("format", 2'(k), INPUT_FORMAT)
			`CHK("pll_mode", 2'(k), PLL_MODE)
			`CHK("lock_mode", 1'b1, LOCK_MODE)
			`CHK("sync_kept", 1'b0, SYNC_SELECT)
		end
		wr(2'h2, 8'h91);
		wr(2'h2, 8'h04);
		`CHK("sync_set", 1'b1, SYNC_SELECT)
		`CHK("fmt_kept", 2'h1, INPUT_FORMAT)
		wr(2'h2, 8'h00);
		`CHK("sync_clear", 1'b0, SYNC_SELECT)
		pfc_host_model_i.bits(1'b0, 8'h16, 8);
		pfc_host_model_i.bits(1'b1, 8'h83, 4);
		pfc_host_model_i.write(2'h2, 8'h83, 6'h06);
		strobe(3);
		`CHK("partial_wrong_addr", 2'h1, INPUT_FORMAT)
	endtask
	task automatic t_volume_swap();
		IN_LEFT  = 20'h20000;
		IN_RIGHT = 20'h20000;
		strobe(1040);
		`CHK("unmuted", 1'b0, MUTE_SILENT)
		v0 = OUT_RIGHT;
		`CHK("left_unity", v0, OUT_LEFT)
		wr(2'h0, 8'h01);
		`CHK("code1", v0, OUT_RIGHT)
		wr(2'h0, 8'h07);
		`CHK("code7", 1'b1, OUT_RIGHT < v0 && OUT_RIGHT != 20'h00000)
		wr(2'h0, 8'h3D);
		`CHK("code61", 1'b1, OUT_RIGHT != 20'h00000)
		wr(2'h0, 8'h3E);
		`CHK("code62", 20'h00000, OUT_RIGHT)
		wr(2'h0, 8'h3F);
		`CHK("code63", 20'h00000, OUT_RIGHT)
		`CHK("left_apart", v0, OUT_LEFT)
		wr(2'h0, 8'h00);
		wr(2'h0, 8'h7E);
		`CHK("left_silent", 20'h00000, OUT_LEFT)
		`CHK("right_apart", v0, OUT_RIGHT)
		wr(2'h0, 8'h40);
		IN_RIGHT = 20'h00000;
		wr(2'h2, 8'h08);
		`CHK("swap_right", v0, OUT_RIGHT)
		`CHK("swap_left", 20'h00000, OUT_LEFT)
		wr(2'h2, 8'h00);
		IN_RIGHT = 20'h20000;
		wr(2'h0, 8'h9F);
		`CHK("flat_bass", v0, OUT_RIGHT)
		wr(2'h0, 8'h19);
		vf = OUT_RIGHT;
		wr(2'h2, 8'h60);
		strobe(300);
		`CHK("max_bass", 1'b1, OUT_RIGHT != vf)
		wr(2'h2, 8'h00);
		wr(2'h0, 8'h00);
		`CHK("back_flat", v0, OUT_RIGHT)
		wr(2'h2, 8'h10);
		IN_RIGHT = 20'h00000;
		strobe(1);
		`CHK("deemph_tail", 1'b1, OUT_RIGHT != 20'h00000)
		IN_RIGHT = 20'h20000;
		wr(2'h2, 8'h00);
	endtask
	task automatic t_mute();
		wr(2'h2, 8'h02);
		n = 3;
		while (MUTE_SILENT !== 1'b1 && n < 1100) begin
			strobe(1);
			n++;
		end
		`CHK("ramp_len", 1'b1, n >= 1023 && n <= 1027)
		wr(2'h2, 8'h00);
		strobe(509);
		`CHK("mid_ramp", 1'b1, OUT_RIGHT != v0 && OUT_RIGHT != 20'h00000)
		strobe(520);
		`CHK("ramp_up", v0, OUT_RIGHT)
	endtask
	task automatic t_conv_reset();
		for (int s = 1; s < 3; s++) begin
			wr(2'h2, 8'h90 | 8'(s << 5));
			wr(2'h2, 8'h01);
			`CHK("conv_reset", 1'b1, CONVERTER_RESET)
			`CHK("conv_valid", 1'b0, valid_seen)
			`CHK("conv_out", 20'h00000, OUT_RIGHT)
			`CHK("conv_unlock", 1'b0, PLL_LOCKED)
			pfc_host_model_i.write(2'h2, 8'h00);
			n = 0;
			while (PLL_LOCKED !== 1'b1 && n < 5000) begin
				strobe(1);
				n++;
			end
			`CHK("lock_count", 1'b1, n >= (1024 << s) - 1 && n <= (1024 << s) + 1)
		end
	endtask
	initial begin
		bad_count       = 0;
		samples_checked = 0;
		RST_N           = 1'b0;
		SAMPLE_STROBE   = 1'b0;
		IN_LEFT         = 20'h00000;
		IN_RIGHT        = 20'h00000;
		repeat (20) @(negedge CLK);
		RST_N = 1'b1;
		`CHK("rst_silent", 1'b1, MUTE_SILENT)
		`CHK("rst_regs", 7'h00, {CONVERTER_RESET, PLL_LOCKED, SYNC_SELECT, INPUT_FORMAT, PLL_MODE})
		t_lock_and_format();
		t_volume_swap();
		t_mute();
		t_conv_reset();
		stop_test();
	end
	initial begin
		repeat (90000) @(posedge CLK);
		bad_count++;
		stop_test();
	end
endmodule
bind pfc_playback_ctrl pfc_playback_ctrl_sva pfc_playback_ctrl_sva_i (.CLK(CLK), .RST_N(RST_N),
	.SAMPLE_STROBE(SAMPLE_STROBE), .OUT_LEFT(OUT_LEFT), .OUT_RIGHT(OUT_RIGHT), .OUT_VALID(OUT_VALID),
	.CONVERTER_RESET(CONVERTER_RESET), .MUTE_SILENT(MUTE_SILENT), .PLL_LOCKED(PLL_LOCKED),
	.SYNC_SELECT(SYNC_SELECT), .INPUT_FORMAT(INPUT_FORMAT), .PLL_MODE(PLL_MODE), .LOCK_MODE(LOCK_MODE));
